/* File: verilog/oclk_pkg.sv */
// Constants for the oscillator control lock and status register block.
// Assumes a single system clock and a plain strobe register port.
package oclk_pkg;
  // ==========================================================
  // Register map
  localparam logic [1:0] OCLK_ADDR_CTRL = 2'h0;
  localparam logic [1:0] OCLK_ADDR_IRQ_STAT = 2'h1;
  localparam logic [1:0] OCLK_ADDR_IRQ_MASK = 2'h2;
  localparam int OCLK_ADDR_W = 2;
  localparam int OCLK_DATA_W = 16;
  // ==========================================================
  // Field positions in the control register
  localparam int OCLK_BIT_FREEZE = 7;
  localparam int OCLK_BIT_PINLOCK = 6;
  localparam int OCLK_BIT_PLLLOCK = 5;
  localparam int OCLK_BIT_FAIL = 3;
  localparam int OCLK_BIT_SECONDARY_OSCILLATOR = 1;
  localparam int OCLK_BIT_SWREQ = 0;
  // ==========================================================
  // Interrupt status bit positions
  localparam int OCLK_IRQ_FAIL = 0;
  localparam int OCLK_IRQ_SWDONE = 1;
  localparam int OCLK_IRQ_PLL = 2;
  localparam int OCLK_IRQ_W = 3;
  // ==========================================================
  // Reset values
  localparam logic [OCLK_IRQ_W-1:0] OCLK_IRQ_RST = 3'h0;
  localparam logic [OCLK_DATA_W-1:0] OCLK_ZERO = 16'h0000;
endpackage : oclk_pkg

/* File: verilog/oclk_osc_control.sv */
// Oscillator control register, low byte: locks, PLL status, clock fail,
// secondary oscillator enable and switch request, plus an interrupt unit.
// Assumes all hardware status inputs except the strap/config levels and the
// same-clock pin map unlock level come from other clocks and are synchronised here; config bits are static.
//
// Notes on behaviour
// - With monitor enabled, set freeze bit blocks clock and PLL switching.
// - With monitor disabled, selections never lock; switch request works.
// - Bit 6 set makes the peripheral pin mapping lock active.
// - Bit 5 reads one when PLL locked or start-up timer expired.
// - Clock-fail flag at bit 3 sets on a detected clock failure.
// - Bits 4 and 2 read zero; writes there do nothing.
// - Bit 1 enables the 32 kHz secondary oscillator.
// - PLL status clears on every valid switch and in non-PLL modes.
// - Pin lock changes only after unlock; one-way config forbids clear.
// - Fail flag software-clear only; freeze bit set only; both reset 0.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module oclk_osc_control
  import oclk_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [OCLK_ADDR_W-1:0] addr_in,
  input wire logic [OCLK_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [OCLK_DATA_W-1:0] rdata_out,
  // Static configuration levels
  input wire logic switch_monitor_cfg_bit_in,
  input wire logic pin_lock_one_shot_cfg_in,
  // Pin map unlock sequence done (same clock, level while unlocked)
  input wire logic pin_map_unlocked_in,
  // Asynchronous status from the oscillator system
  input wire logic pll_locked_in,
  input wire logic pll_timer_done_in,
  input wire logic pll_mode_in,
  input wire logic clock_fail_det_in,
  input wire logic switch_done_in,
  input wire logic switch_abort_in,
  // Controls to the clock system
  output logic switch_start_out,
  output logic selection_frozen_out,
  output logic pin_map_freeze_out,
  output logic secondary_osc_enable_out,
  output logic irq_out
);

  // ==========================================================
  // Synchronisers
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_a_r;
  logic [NSYNC-1:0] sync_b_r;
  logic [NSYNC-1:0] sync_nxt;
  logic [NSYNC-1:0] sync_d_r;
  logic pll_locked_s;
  logic pll_timer_s;
  logic pll_mode_s;
  logic fail_s;
  logic done_s;
  logic abort_s;

  always_comb begin
    sync_nxt = {pll_locked_in, pll_timer_done_in, pll_mode_in,
                clock_fail_det_in, switch_done_in, switch_abort_in};
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a_r <= '0;
      sync_b_r <= '0;
      sync_d_r <= '0;
    end else begin
      sync_a_r <= sync_nxt;
      sync_b_r <= sync_a_r;
      sync_d_r <= sync_b_r;
    end
  end

  assign pll_locked_s = sync_b_r[5];
  assign pll_timer_s = sync_b_r[4];
  assign pll_mode_s = sync_b_r[3];
  assign fail_s = sync_b_r[2];
  assign done_s = sync_b_r[1];
  assign abort_s = sync_b_r[0];

  // Edge events: rising edges of the synchronised levels
  logic fail_rise;
  logic done_rise;
  logic abort_rise;
  assign fail_rise = fail_s & ~sync_d_r[2];
  assign done_rise = done_s & ~sync_d_r[1];
  assign abort_rise = abort_s & ~sync_d_r[0];

  // ==========================================================
  // Register port decode
  // All strobes are single cycle; a read has no side effect
  function automatic logic port_hit(
    input logic strobe,
    input logic [OCLK_ADDR_W-1:0] addr,
    input logic [OCLK_ADDR_W-1:0] target
  );
    return strobe && (addr == target);
  endfunction : port_hit

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic rd_ctrl;
  logic rd_stat;
  logic rd_mask;

  assign wr_ctrl = port_hit(wr_in, addr_in, OCLK_ADDR_CTRL);
  assign wr_stat = port_hit(wr_in, addr_in, OCLK_ADDR_IRQ_STAT);
  assign wr_mask = port_hit(wr_in, addr_in, OCLK_ADDR_IRQ_MASK);
  assign rd_ctrl = port_hit(rd_in, addr_in, OCLK_ADDR_CTRL);
  assign rd_stat = port_hit(rd_in, addr_in, OCLK_ADDR_IRQ_STAT);
  assign rd_mask = port_hit(rd_in, addr_in, OCLK_ADDR_IRQ_MASK);

  // ==========================================================
  // Clock selection freeze and switch request
  logic freeze_r;
  logic freeze_nxt;
  logic swreq_r;
  logic swreq_nxt;
  logic locked;
  logic switch_end;

  // Monitor enabled when the configuration bit is one
  assign locked = switch_monitor_cfg_bit_in & freeze_r;
  assign switch_end = done_rise | abort_rise;

  always_comb begin
    freeze_nxt = freeze_r;
    swreq_nxt = swreq_r;
    if (wr_ctrl) begin
      // Freeze may only be set by software; a zero write is ignored
      if (wdata_in[OCLK_BIT_FREEZE]) begin
        freeze_nxt = 1'b1;
      end
      // Request accepted only while selections are unlocked
      if (wdata_in[OCLK_BIT_SWREQ] && !locked) begin
        swreq_nxt = 1'b1;
      end else if (!wdata_in[OCLK_BIT_SWREQ]) begin
        swreq_nxt = 1'b0;
      end
    end
    // Completion or abandon ends the request whatever software wrote
    if (swreq_r && switch_end) begin
      swreq_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      freeze_r <= 1'b0;
      swreq_r <= 1'b0;
    end else begin
      freeze_r <= freeze_nxt;
      swreq_r <= swreq_nxt;
    end
  end

  // ==========================================================
  // Peripheral pin mapping lock
  logic pinlock_r;
  logic pinlock_nxt;
  logic pin_clear_blocked;

  // One-way setting: once set, a clearing write is dropped
  assign pin_clear_blocked = pin_lock_one_shot_cfg_in & pinlock_r;

  // Unlock level is on this clock, so it is read directly
  always_comb begin
    pinlock_nxt = pinlock_r;
    if (wr_ctrl && pin_map_unlocked_in) begin
      if (wdata_in[OCLK_BIT_PINLOCK] || !pin_clear_blocked) begin
        pinlock_nxt = wdata_in[OCLK_BIT_PINLOCK];
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pinlock_r <= 1'b0;
    end else begin
      pinlock_r <= pinlock_nxt;
    end
  end

  // ==========================================================
  // PLL status and clock-fail flag
  logic pll_ok_r;
  logic pll_ok_nxt;
  logic fail_r;
  logic fail_nxt;
  logic pll_status;

  assign pll_status = pll_mode_s & (pll_locked_s | pll_timer_s);

  always_comb begin
    pll_ok_nxt = pll_status;
    fail_nxt = fail_r;
    // Fail flag may only be cleared by software
    if (wr_ctrl && !wdata_in[OCLK_BIT_FAIL]) begin
      fail_nxt = 1'b0;
    end
    // A failure in the same cycle as a clear must not be lost
    if (fail_rise) begin
      fail_nxt = 1'b1;
    end
    // Status drops for one cycle on a completed switch
    if (done_rise) begin
      pll_ok_nxt = 1'b0;
    end
    if (!pll_mode_s) begin
      pll_ok_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_ok_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      pll_ok_r <= pll_ok_nxt;
      fail_r <= fail_nxt;
    end
  end

  // ==========================================================
  // Secondary oscillator enable
  logic secondary_oscillator_r;
  logic secondary_oscillator_nxt;

  // Enable follows every control write; no lock applies to it
  always_comb begin
    secondary_oscillator_nxt = secondary_oscillator_r;
    if (wr_ctrl) begin
      secondary_oscillator_nxt = wdata_in[OCLK_BIT_SECONDARY_OSCILLATOR];
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      secondary_oscillator_r <= 1'b0;
    end else begin
      secondary_oscillator_r <= secondary_oscillator_nxt;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [OCLK_IRQ_W-1:0] istat_r;
  logic [OCLK_IRQ_W-1:0] istat_nxt;
  logic [OCLK_IRQ_W-1:0] imask_r;
  logic [OCLK_IRQ_W-1:0] imask_nxt;
  logic [OCLK_IRQ_W-1:0] ievent;

  always_comb begin
    ievent = OCLK_IRQ_RST;
    ievent[OCLK_IRQ_FAIL] = fail_rise;
    ievent[OCLK_IRQ_SWDONE] = swreq_r & switch_end;
    ievent[OCLK_IRQ_PLL] = pll_status & ~pll_ok_r;
  end

  always_comb begin
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    // Write one to clear
    if (wr_stat) begin
      istat_nxt = istat_r & ~wdata_in[OCLK_IRQ_W-1:0];
    end
    if (wr_mask) begin
      imask_nxt = wdata_in[OCLK_IRQ_W-1:0];
    end
    // New events win over a same-cycle clear
    istat_nxt = istat_nxt | ievent;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      istat_r <= OCLK_IRQ_RST;
      imask_r <= OCLK_IRQ_RST;
    end else begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
    end
  end

  // ==========================================================
  // Read data
  logic [OCLK_DATA_W-1:0] rdata_nxt;

  // Unimplemented positions stay zero in the assembled word
  function automatic logic [OCLK_DATA_W-1:0] ctrl_word(
    input logic freeze,
    input logic pinlock,
    input logic pll_ok,
    input logic fail,
    input logic secondary_oscillator,
    input logic swreq
  );
    logic [OCLK_DATA_W-1:0] word;
    word = OCLK_ZERO;
    word[OCLK_BIT_FREEZE] = freeze;
    word[OCLK_BIT_PINLOCK] = pinlock;
    word[OCLK_BIT_PLLLOCK] = pll_ok;
    word[OCLK_BIT_FAIL] = fail;
    word[OCLK_BIT_SECONDARY_OSCILLATOR] = secondary_oscillator;
    word[OCLK_BIT_SWREQ] = swreq;
    return word;
  endfunction : ctrl_word

  // Registered, so read data stand exactly one cycle and are zero after
  always_comb begin
    rdata_nxt = OCLK_ZERO;
    if (rd_ctrl) begin
      rdata_nxt = ctrl_word(freeze_r, pinlock_r, pll_ok_r, fail_r, secondary_oscillator_r,
                            swreq_r);
    end else if (rd_stat) begin
      rdata_nxt[OCLK_IRQ_W-1:0] = istat_r;
    end else if (rd_mask) begin
      rdata_nxt[OCLK_IRQ_W-1:0] = imask_r;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= OCLK_ZERO;
    end else begin
      rdata_out <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Frozen flag is combinational so a lock acts on the very next write
  assign switch_start_out = swreq_r;
  assign selection_frozen_out = locked;
  assign pin_map_freeze_out = pinlock_r;
  assign secondary_osc_enable_out = secondary_oscillator_r;
  assign irq_out = |(istat_r & imask_r);

endmodule : oclk_osc_control

/* File: tb/oclk_osc_control_asserts.sv */
// Port assertions for the oscillator control block.
// Bound to every oclk_osc_control instance; one clock, async reset.
`timescale 1ns/1ps
module oclk_osc_control_asserts
  import oclk_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [OCLK_ADDR_W-1:0] addr_in,
  input wire logic [OCLK_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [OCLK_DATA_W-1:0] rdata_out,
  // Configuration and status
  input wire logic switch_monitor_cfg_bit_in,
  input wire logic pin_lock_one_shot_cfg_in,
  input wire logic pin_map_unlocked_in,
  input wire logic switch_done_in,
  // Controls out
  input wire logic switch_start_out,
  input wire logic selection_frozen_out,
  input wire logic pin_map_freeze_out,
  input wire logic secondary_osc_enable_out
);
  // ==========================================
  // Properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence ctrl_wr;
    wr_in && addr_in == OCLK_ADDR_CTRL;
  endsequence
  sequence swreq_wr;
    ctrl_wr ##0 wdata_in[OCLK_BIT_SWREQ];
  endsequence
  a_never_frozen: assert property (
    !switch_monitor_cfg_bit_in |-> !selection_frozen_out)
    else $error("selection frozen with monitor disabled");
  a_frozen_block: assert property (
    swreq_wr ##0 (selection_frozen_out && !switch_start_out)
    |=> !switch_start_out) else $error("switch request taken while frozen");
  a_swreq_set: assert property (
    swreq_wr ##0 !selection_frozen_out |=> switch_start_out)
    else $error("switch request not taken");
  a_secondary_oscillator_write: assert property (
    ctrl_wr |=> secondary_osc_enable_out == $past(wdata_in[OCLK_BIT_SECONDARY_OSCILLATOR]))
    else $error("secondary oscillator enable not written");
  a_pin_hold: assert property (
    !(wr_in && addr_in == OCLK_ADDR_CTRL && pin_map_unlocked_in)
    |=> $stable(pin_map_freeze_out)) else $error("pin lock changed while locked");
  a_pin_oneway: assert property (
    pin_map_freeze_out && pin_lock_one_shot_cfg_in |=> pin_map_freeze_out)
    else $error("one-way pin lock cleared");
  a_rd_gaps: assert property (
    rd_in && addr_in == OCLK_ADDR_CTRL |=>
    rdata_out[4] == 1'b0 && rdata_out[2] == 1'b0)
    else $error("unimplemented bit reads one");
  a_rd_fields: assert property (
    rd_in && addr_in == OCLK_ADDR_CTRL |=>
    rdata_out[OCLK_BIT_PINLOCK] == $past(pin_map_freeze_out) &&
    rdata_out[OCLK_BIT_SECONDARY_OSCILLATOR] == $past(secondary_osc_enable_out))
    else $error("control read disagrees with outputs");
  a_swreq_clr: assert property (
    switch_start_out && $rose(switch_done_in) |-> ##[1:4] !switch_start_out)
    else $error("switch request not cleared on completion");
endmodule : oclk_osc_control_asserts

bind oclk_osc_control oclk_osc_control_asserts i_chk (.*);

/* File: tb/oclk_osc_control_tb.sv */
// Self-checking bench for the oscillator control block.
// Drives every port itself; the checker is bound from its own file.
`timescale 1ns/1ps
module oclk_osc_control_tb;
  import oclk_pkg::*;
  logic clock_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0;
  logic [1:0] addr_in = '0;
  logic [15:0] wdata_in = '0, rdata_out, d;
  logic switch_monitor_cfg_bit_in = 0, pin_lock_one_shot_cfg_in = 0;
  logic pin_map_unlocked_in = 1, pll_locked_in = 0, pll_timer_done_in = 0;
  logic pll_mode_in = 0, clock_fail_det_in = 0;
  logic switch_done_in = 0, switch_abort_in = 0;
  logic switch_start_out, selection_frozen_out, pin_map_freeze_out;
  logic secondary_osc_enable_out, irq_out;
  int failures = 0, tests_run = 0, cyc = 0;
  oclk_osc_control i_oclk_osc_control (.*);
  initial forever #20 clock_in = ~clock_in;
  // A hang costs at most this many cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      results();
    end
  end
  // ==========================================
  // Helpers
  task automatic results();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1;
  endtask : acc
  task automatic rdc(input logic [1:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(rdata_out, e);
  endtask : rdc
  // Synchroniser plus register: three edges, one spare
  task automatic wt();
    repeat (4) @(posedge clock_in);
    #1;
  endtask : wt
  // Only pin lock and oscillator enable survive with freeze and request off
  function automatic logic [15:0] exp_ctrl(input logic [15:0] v);
    return v & 16'h0042;
  endfunction : exp_ctrl
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'hbb5ee80a));
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    acc(1'b1, OCLK_ADDR_IRQ_MASK, 16'h0007);
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom) & 16'hff7e;
      acc(1'b1, OCLK_ADDR_CTRL, d);
      rdc(OCLK_ADDR_CTRL, exp_ctrl(d));
    end
    rdc(2'h3, OCLK_ZERO);
    for (int i = 1; i < 3; i++) begin
      acc(1'b1, OCLK_ADDR_CTRL, 16'h0001);
      chk(16'(switch_start_out), 16'h0001);
      {switch_abort_in, switch_done_in} <= 2'(i);
      wt();
      chk(16'(switch_start_out), 16'h0000);
      {switch_abort_in, switch_done_in} <= 2'h0;
    end
    chk(16'(irq_out), 16'h0001);
    rdc(OCLK_ADDR_IRQ_STAT, 16'h0002);
    acc(1'b1, OCLK_ADDR_IRQ_STAT, 16'h0002);
    chk(16'(irq_out), 16'h0000);
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0080);
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0081);
    chk(16'(switch_start_out), 16'h0001);
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0080);
    switch_monitor_cfg_bit_in <= 1'b1;
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0001);
    chk(16'({selection_frozen_out, switch_start_out}), 16'h0002);
    rdc(OCLK_ADDR_CTRL, 16'h0080);
    pll_mode_in <= 1'b1;
    pll_locked_in <= 1'b1;
    wt();
    rdc(OCLK_ADDR_CTRL, 16'h00a0);
    pll_mode_in <= 1'b0;
    wt();
    rdc(OCLK_ADDR_CTRL, 16'h0080);
    clock_fail_det_in <= 1'b1;
    wt();
    rdc(OCLK_ADDR_CTRL, 16'h0088);
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0080);
    rdc(OCLK_ADDR_CTRL, 16'h0080);
    acc(1'b1, OCLK_ADDR_IRQ_MASK, 16'h0000);
    chk(16'(irq_out), 16'h0000);
    acc(1'b1, OCLK_ADDR_IRQ_STAT, 16'h0007);
    acc(1'b1, OCLK_ADDR_IRQ_MASK, 16'h0007);
    chk(16'(irq_out), 16'h0000);
    acc(1'b1, OCLK_ADDR_CTRL, 16'h00c0);
    pin_map_unlocked_in <= 1'b0;
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0080);
    chk(16'(pin_map_freeze_out), 16'h0001);
    pin_map_unlocked_in <= 1'b1;
    pin_lock_one_shot_cfg_in <= 1'b1;
    acc(1'b1, OCLK_ADDR_CTRL, 16'h0080);
    chk(16'(pin_map_freeze_out), 16'h0001);
    results();
  end
endmodule : oclk_osc_control_tb
